// >>> hdl/optical_line_pkg.sv
// shared constants and types for the three-level optical line encoder
package optical_line_pkg;

  // core clock
  localparam int CLK_NS = 50; // 20 MHz period in ns
  localparam int CLK_KHZ = 20000; // core clock rate in kHz

  // refresh pulse timing
  localparam int REFRESH_PULSE_WIDTH_NS = 40; // excursion length in ns
  localparam int REFRESH_RATE_KHZ = 400; // excursion repetition rate
  localparam int PULSE_CYC = (REFRESH_PULSE_WIDTH_NS / CLK_NS) < 1 ? 1 :
    (REFRESH_PULSE_WIDTH_NS / CLK_NS); // pulse length in cycles
  localparam int REFRESH_CYC = CLK_KHZ / REFRESH_RATE_KHZ; // period cycles

  // data input limits kept by the driving party
  localparam int DATA_MIN_NS = 100; // shortest high or low interval
  localparam int DATA_MIN_CYC = DATA_MIN_NS / CLK_NS; // in core cycles

  // timer counters
  localparam int CNT_W = 6; // wide enough for REFRESH_CYC
  localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYC - 1);
  localparam logic [CNT_W-1:0] PERIOD_LOAD = CNT_W'(REFRESH_CYC - 1);

  // buffer between synchroniser and encoder
  localparam int BUF_DEPTH = 32; // words held in flight

  // drive level code toward the optical emitter
  typedef enum logic [1:0] {
    FLOOR_POWER_LEVEL = 2'h0, // near-zero emission
    MID_POWER_LEVEL = 2'h1, // mid level, about half of peak
    PEAK_POWER_LEVEL = 2'h2 // full emission
  } level_t;

  // encoder states, one-hot
  typedef enum logic [2:0] {
    ST_EXT = 3'h1, // two-level, follows data
    ST_MID = 3'h2, // three-level, resting at mid
    ST_PULSE = 3'h4 // three-level, refresh excursion
  } enc_state_t;

  // one line sample: mode select and data input
  typedef struct packed {
    logic mode; // high selects the two-level mode
    logic data; // data input level
  } line_word_t;

  localparam line_word_t LINE_WORD_RST = '{mode: 1'b0, data: 1'b0};

endpackage : optical_line_pkg

// >>> hdl/line_word_fifo.sv
// small fifo with registered read data for line samples
`timescale 1ns/1ps
`default_nettype none
module line_word_fifo #(
  parameter int WIDTH = 2, // word width
  parameter int DEPTH = 32 // words, a power of two
) (
  input wire logic clock, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // offered word
  output logic out_valid, // read word present
  input wire logic out_ready, // reader takes the word
  output logic [WIDTH-1:0] out_data, // read word, from a register
  output logic full, // no room left
  output logic empty // nothing stored or presented
);
  localparam int AW = $clog2(DEPTH); // pointer width
  localparam int CW = $clog2(DEPTH + 1); // count width

  // whole state of the fifo
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage
    logic [AW-1:0] wp; // write pointer
    logic [AW-1:0] rp; // read pointer
    logic [CW-1:0] cnt; // words in storage
    logic ov; // output register holds a word
    logic [WIDTH-1:0] od; // output register
  } fifo_state_t;

  fifo_state_t r; // current state
  fifo_state_t n; // next state
  logic push; // write accepted
  logic load; // storage to output register

  // handshake flags straight from the count and the output register flag
  assign in_ready = (r.cnt != CW'(DEPTH));
  assign full = !in_ready;
  assign empty = (r.cnt == '0) && !r.ov;
  assign out_valid = r.ov;
  assign out_data = r.od;

  // next state: write, prefetch into the output register
  always_comb begin
    n = r;
    push = in_valid && in_ready;
    load = (r.cnt != '0) && (!r.ov || out_ready);
    if (push) begin
      n.mem[r.wp] = in_data;
      n.wp = r.wp + 1'b1;
    end
    if (load) begin
      n.od = r.mem[r.rp];
      n.rp = r.rp + 1'b1;
      n.ov = 1'b1;
    end else if (out_ready) begin
      n.ov = 1'b0;
    end
    if (push && !load) begin
      n.cnt = r.cnt + 1'b1;
    end else if (load && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule : line_word_fifo
`default_nettype wire

// >>> hdl/three_level_optical_line_encoder.sv
// three-level / two-level optical drive encoder with refresh pulses
// Summary of operation
// [R01] mode low three-level, mode high two-level
// [R02] three-level: mid, excursions follow data polarity
// [R03] excursion about 40 ns, repeating at 400 kHz; the code's excursion is one 50 ns clock cycle (PULSE_CYC = 1)
// [R04] new train starts at once, full pulse
// [R05] data toggle cuts pulse, opposite train begins
// [R06] average stays mid for any data timing
// [R07] two-level: peak when high, floor when low
// [R08] driver uses self-clocking code in two-level mode
// [R09] driver may hold data for diagnostics or standby
// [R10] driver keeps data intervals at least 100 ns
// [R11] data accepted from dc to 10 Mbaud
// [R12] driver budgets bit rate per code intervals
// [R13] two-bit level code, clock-derived pulse counters
// [R14] data and mode synchronised before edge use
`timescale 1ns/1ps
`default_nettype none
module three_level_optical_line_encoder
  import optical_line_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH // buffered line samples
) (
  input wire logic clock, // 20 MHz core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic mode_select, // async pin, high selects two-level
  input wire logic data_in, // async data pin
  input wire logic drive_ready, // emitter driver takes new samples
  output logic [1:0] level_code, // drive level, from a register
  output logic input_ready, // buffer has room for a change
  output logic buffer_full // buffer holds DEPTH samples
);

  // whole state of the encoder
  typedef struct packed {
    line_word_t s1; // synchroniser stage one
    line_word_t s2; // synchroniser stage two
    line_word_t s3; // synchroniser stage three
    line_word_t acc; // accepted pin levels
    line_word_t sent; // last sample written to the buffer
    line_word_t cur; // sample driving the encoder
    enc_state_t st; // encoder state
    logic [CNT_W-1:0] pulse_cnt; // cycles left in the excursion
    logic [CNT_W-1:0] period_cnt; // cycles to the next excursion
    level_t level; // registered drive level
  } enc_reg_t;

  localparam enc_reg_t ENC_RST = '{
    s1: LINE_WORD_RST, s2: LINE_WORD_RST, s3: LINE_WORD_RST,
    acc: LINE_WORD_RST, sent: LINE_WORD_RST, cur: LINE_WORD_RST,
    st: ST_MID, pulse_cnt: '0, period_cnt: PERIOD_LOAD,
    level: MID_POWER_LEVEL};

  enc_reg_t r; // current state
  enc_reg_t n; // next state
  logic push; // offer accepted levels to the buffer
  logic push_ready; // buffer room
  logic pop_valid; // buffered sample present
  line_word_t pop_word; // buffered sample
  logic take; // encoder consumes a sample
  logic new_train; // three-level sample taken after two-level mode or with flipped data

  // buffer of synchronised changes; driver readiness drains it
  line_word_fifo #(
    .WIDTH($bits(line_word_t)),
    .DEPTH(DEPTH)
  ) u_buf (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(r.acc),
    .out_valid(pop_valid),
    .out_ready(drive_ready),
    .out_data(pop_word),
    .full(buffer_full),
    .empty()
  );

  assign input_ready = push_ready;
  assign level_code = r.level; // R13
  assign push = (r.acc != r.sent);
  assign take = pop_valid && drive_ready;
  assign new_train = take && !pop_word.mode &&
    (r.cur.mode || (pop_word.data != r.cur.data)); // R04 R05

  // next state: synchronise, buffer, time the refresh pulses
  always_comb begin
    n = r;
    // three stages, change counts once stages two and three agree
    n.s1 = '{mode: mode_select, data: data_in}; // R14
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.acc = r.s3; // R14 R11
    end
    // a change waits in acc while the buffer is full
    if (push && push_ready) begin
      n.sent = r.acc;
    end
    if (take) begin
      n.cur = pop_word;
    end
    if (take && pop_word.mode) begin
      n.st = ST_EXT; // R01
    end else if (new_train) begin
      // restart at once with a full-length excursion
      n.st = ST_PULSE; // R04 R05
      n.pulse_cnt = PULSE_LOAD;
      n.period_cnt = PERIOD_LOAD;
    end else begin
      case (r.st)
        ST_EXT: begin
          n.st = ST_EXT; // held until a three-level sample arrives
        end
        ST_MID: begin
          if (r.period_cnt == '0) begin
            n.st = ST_PULSE; // R03
            n.pulse_cnt = PULSE_LOAD;
            n.period_cnt = PERIOD_LOAD;
          end else begin
            n.period_cnt = r.period_cnt - 1'b1;
          end
        end
        ST_PULSE: begin
          n.period_cnt = r.period_cnt - 1'b1;
          if (r.pulse_cnt == '0) begin
            n.st = ST_MID; // R03 R06
          end else begin
            n.pulse_cnt = r.pulse_cnt - 1'b1;
          end
        end
        default: begin
          n.st = ST_MID;
        end
      endcase
    end
    // drive level from next state and sample
    case (n.st)
      ST_EXT: n.level = n.cur.data ? PEAK_POWER_LEVEL :
        FLOOR_POWER_LEVEL; // R07
      ST_PULSE: n.level = n.cur.data ? PEAK_POWER_LEVEL :
        FLOOR_POWER_LEVEL; // R02
      ST_MID: n.level = MID_POWER_LEVEL; // R02
      default: n.level = MID_POWER_LEVEL;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= ENC_RST;
    end else begin
      r <= n;
    end
  end

  // helper: length of the running excursion
  logic [CNT_W-1:0] pulse_len_r; // cycles spent in ST_PULSE
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pulse_len_r <= '0;
    end else if (r.st == ST_PULSE && !new_train) begin
      pulse_len_r <= pulse_len_r + 1'b1;
    end else begin
      pulse_len_r <= '0;
    end
  end

  localparam int PC = PULSE_CYC; // local copy for assertions

  // mode high sample leads to the two-level state
  property p_mode_ext;
    @(posedge clock) disable iff (!rst_n)
      take && pop_word.mode |=> r.st == ST_EXT;
  endproperty
  a_mode_ext: assert property (p_mode_ext) // R01
    else $error("mode high did not enter two-level state");

  // mid state shows mid level only
  property p_mid_level;
    @(posedge clock) disable iff (!rst_n)
      r.st == ST_MID |-> r.level == MID_POWER_LEVEL;
  endproperty
  a_mid_level: assert property (p_mid_level) // R02
    else $error("mid state not at mid level");

  // idle mid with expired period starts an excursion
  property p_refresh_rate;
    @(posedge clock) disable iff (!rst_n)
      r.st == ST_MID && r.period_cnt == '0 && !take
      |=> r.st == ST_PULSE && r.period_cnt == PERIOD_LOAD;
  endproperty
  a_refresh_rate: assert property (p_refresh_rate) // R03
    else $error("refresh excursion not started on time");

  // flip starts a full excursion of the new polarity at once
  property p_new_train;
    @(posedge clock) disable iff (!rst_n)
      new_train |=> r.st == ST_PULSE && r.pulse_cnt == PULSE_LOAD
      && r.level == (r.cur.data ? PEAK_POWER_LEVEL : FLOOR_POWER_LEVEL);
  endproperty
  a_new_train: assert property (p_new_train) // R04 R05
    else $error("new pulse train not started at full length");

  // no excursion runs longer than the pulse width
  property p_pulse_width;
    @(posedge clock) disable iff (!rst_n)
      pulse_len_r <= CNT_W'(PC);
  endproperty
  a_pulse_width: assert property (p_pulse_width) // R06 R03
    else $error("refresh excursion too long");

  // an undisturbed excursion ends back at mid
  property p_pulse_end;
    @(posedge clock) disable iff (!rst_n)
      r.st == ST_PULSE && r.pulse_cnt == '0 && !take
      |=> r.level == MID_POWER_LEVEL;
  endproperty
  a_pulse_end: assert property (p_pulse_end) // R06
    else $error("excursion did not return to mid");

  // two-level state follows data with no refresh
  property p_ext_level;
    @(posedge clock) disable iff (!rst_n)
      r.st == ST_EXT && !take |=> r.st == ST_EXT &&
      r.level == ($past(r.cur.data) ? PEAK_POWER_LEVEL :
      FLOOR_POWER_LEVEL);
  endproperty
  a_ext_level: assert property (p_ext_level) // R07
    else $error("two-level output does not follow data");

  // level code is one of the three levels
  property p_level_code;
    @(posedge clock) disable iff (!rst_n)
      level_code != 2'h3;
  endproperty
  a_level_code: assert property (p_level_code) // R13
    else $error("illegal level code");

  // accepted levels move only when stages two and three agree
  property p_sync_accept;
    @(posedge clock) disable iff (!rst_n)
      r.acc != $past(r.acc) |-> $past(r.s2 == r.s3);
  endproperty
  a_sync_accept: assert property (p_sync_accept) // R14
    else $error("unsynchronised input accepted");

  // main scenarios
  c_ext: cover property (@(posedge clock) disable iff (!rst_n)
    r.st == ST_EXT ##1 r.st == ST_PULSE);
  c_refresh: cover property (@(posedge clock) disable iff (!rst_n)
    r.st == ST_MID ##1 r.st == ST_PULSE);
  c_cut: cover property (@(posedge clock) disable iff (!rst_n)
    r.st == ST_PULSE && new_train);
  c_full: cover property (@(posedge clock) disable iff (!rst_n)
    buffer_full);

endmodule : three_level_optical_line_encoder
`default_nettype wire

// >>> bench/optical_rx_model.sv
// receiver-side model: recovers data from the drive level, drains samples
`timescale 1ns/1ps
`default_nettype none
module optical_rx_model
  import optical_line_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst_n, // sync reset, active low
  input wire logic [1:0] level_code, // drive level on the fiber
  input wire logic stall, // bench holds the driver off
  output logic drive_ready, // driver takes samples
  output logic rx_data // recovered data level
);
  // driver takes samples unless stalled
  assign drive_ready = !stall;
  // peak means high, floor means low, mid keeps the last level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rx_data <= 1'b0;
    end else if (level_code == PEAK_POWER_LEVEL) begin
      rx_data <= 1'b1;
    end else if (level_code == FLOOR_POWER_LEVEL) begin
      rx_data <= 1'b0;
    end
  end
endmodule : optical_rx_model
`default_nettype wire

// >>> bench/three_level_optical_line_encoder_bench.sv
// self-checking bench for the three-level optical line encoder
`timescale 1ns/1ps
`default_nettype none
module three_level_optical_line_encoder_bench;
  import optical_line_pkg::*;
  logic clock, rst_n, mode_select, data_in, stall; // bench drives
  logic drive_ready, rx_data, input_ready, buffer_full; // observed
  logic [1:0] level_code; // drive level
  int error_cnt = 0, cmp_count = 0, c, k;
  logic [31:0] seed = 32'h2f8a; // fixed seed
  logic bit_v; // current code bit

  three_level_optical_line_encoder i_dut (.clock(clock), .rst_n(rst_n),
    .mode_select(mode_select), .data_in(data_in), .drive_ready(drive_ready),
    .level_code(level_code), .input_ready(input_ready),
    .buffer_full(buffer_full));
  optical_rx_model i_rx (.clock(clock), .rst_n(rst_n),
    .level_code(level_code), .stall(stall), .drive_ready(drive_ready),
    .rx_data(rx_data));

  // clock, 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // xorshift random source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // level expected at rest for mode and data
  function automatic logic [1:0] rest_lvl(input logic m, input logic d);
    return m ? (d ? PEAK_POWER_LEVEL : FLOOR_POWER_LEVEL) : MID_POWER_LEVEL;
  endfunction : rest_lvl
  // excursion level for a data level
  function automatic logic [1:0] pulse_lvl(input logic d);
    return d ? PEAK_POWER_LEVEL : FLOOR_POWER_LEVEL;
  endfunction : pulse_lvl
  // compare and count
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  // verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // wait at falling edges until a level shows, bounded
  task automatic wait_lvl(input logic [1:0] l, output int n);
    n = 0;
    while (level_code !== l && n < 200) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_lvl
  // reset held for 3 cycles, then sync chain flushed
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    check("reset level", level_code, MID_POWER_LEVEL);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask : do_reset

  // watchdog
  initial begin
    #(20000 * CLK_NS);
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    mode_select = 1'b0; // three-level
    data_in = 1'b0;
    stall = 1'b0;
    do_reset();
    // first pulse, width, period for both polarities
    for (int p = 0; p < 2; p++) begin
      data_in = !data_in; // held far longer than 100 ns
      wait_lvl(pulse_lvl(data_in), c);
      check("pulse start", c <= 8, 1'b1);
      @(negedge clock);
      check("pulse width", level_code, MID_POWER_LEVEL);
      wait_lvl(pulse_lvl(data_in), c);
      check("pulse period", c + 1, REFRESH_CYC);
    end
    $display("test three-level pulses done");
    // two-level, Manchester halves, two intervals per bit
    mode_select = 1'b1;
    for (int b = 0; b < 16; b++) begin
      bit_v = 1'(rnd() % 2);
      for (int h = 0; h < 2; h++) begin
        data_in = bit_v ^ h[0];
        repeat (8) @(negedge clock);
        check("two-level", level_code, rest_lvl(1'b1, data_in));
      end
    end
    repeat (40) @(negedge clock); // steady hold, diagnostics style
    check("two-level hold", level_code, rest_lvl(1'b1, data_in));
    $display("test two-level done");
    // back to three-level starts a pulse at once
    mode_select = 1'b0;
    // two-level already shows the pulse level, so wait for the drop to mid
    wait_lvl(MID_POWER_LEVEL, c);
    check("mode change pulse", c <= 9, 1'b1);
    // next refresh one full period after the entry pulse
    wait_lvl(pulse_lvl(data_in), c);
    check("mode change period", c + 1, REFRESH_CYC);
    // random three-level data, shortest and long intervals
    for (int i = 0; i < 30; i++) begin
      data_in = !data_in;
      k = (rnd() % 3 == 0) ? 2 : 10 + rnd() % 60;
      repeat (k) @(negedge clock);
      if (k > 2) begin
        check("recovered data", rx_data, data_in);
      end
      check("never code 3", level_code !== 2'h3, 1'b1);
    end
    $display("test random three-level done");
    // stalled driver fills the buffer until it refuses
    stall = 1'b1;
    k = 0;
    while (buffer_full !== 1'b1 && k < 200) begin
      data_in = !data_in;
      repeat (3) @(negedge clock);
      k++;
    end
    check("buffer full", buffer_full, 1'b1);
    check("input refused", input_ready, 1'b0);
    stall = 1'b0;
    repeat (300) @(negedge clock);
    check("buffer drained", buffer_full, 1'b0);
    check("input ready", input_ready, 1'b1);
    check("drained data", rx_data, data_in);
    $display("test buffer done");
    do_reset(); // second reset in mid-run
    // after release a train of the pin polarity shows within one period
    wait_lvl(pulse_lvl(data_in), c);
    check("reset recovery", c < REFRESH_CYC, 1'b1);
    $display("test second reset done");
    give_verdict();
  end
endmodule : three_level_optical_line_encoder_bench
`default_nettype wire
